// ==== src/ctas_center_terminal.sv ====
// Center terminal amplifier B/C control register and channel input select registers
`timescale 1ns/1ps
`default_nettype none
`include "ctas_regs.svh"

// Functional notes
// - Eight-bit register at 0x19 with four fields
// - Bit 7 powers amplifier C, reset off
// - Bit 6 powers amplifier B, reset off
// - Amp B code picks one of eight electrodes
// - Amp C code uses same electrode ordering
// - Codes 110/111 route leg drive to P/N
// - Leg drive measured against drive reference
// - Two amps average, one amp buffers
module ctas_center_terminal
	import ctas_pkg::*;
#(
	parameter int CH_COUNT = `CTAS_CH_COUNT
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output logic      [7:0]           reg_rdata,
	// Amplifier controls
	output logic                      amp_b_power_on,
	output logic                      amp_c_power_on,
	output logic      [7:0]           amp_b_electrode,
	output logic      [7:0]           amp_c_electrode,
	output ctas_term_mode_t           term_mode,
	// Leg drive routing
	output logic      [CH_COUNT-1:0]  leg_drive_to_p,
	output logic      [CH_COUNT-1:0]  leg_drive_to_n,
	output logic      [CH_COUNT-1:0]  leg_drive_vs_reference
);

	logic [7:0]          center_terminal_bc_control_reg;
	logic [2:0]          channel_input_select_reg [CH_COUNT];
	logic [7:0]          reg_rdata_next;
	logic [2:0]          amp_b_input_select;
	logic [2:0]          amp_c_input_select;
	ctas_term_mode_t     term_mode_next;

	// Control register write
	always_ff @(posedge clk) begin
		if (rst) begin
			center_terminal_bc_control_reg <= `CTAS_BC_CONTROL_RESET;
		end else if (reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR) begin
			center_terminal_bc_control_reg <= reg_wdata;
		end
	end

	assign amp_c_power_on     = center_terminal_bc_control_reg[`CTAS_AMP_C_POWER_BIT];
	assign amp_b_power_on     = center_terminal_bc_control_reg[`CTAS_AMP_B_POWER_BIT];
	assign amp_b_input_select = center_terminal_bc_control_reg[`CTAS_AMP_B_SEL_HI:`CTAS_AMP_B_SEL_LO];
	assign amp_c_input_select = center_terminal_bc_control_reg[`CTAS_AMP_C_SEL_HI:`CTAS_AMP_C_SEL_LO];

	// Electrode one-hot selects: bit 2k is channel k+1 positive, 2k+1 its negative
	always_ff @(posedge clk) begin
		if (rst) begin
			amp_b_electrode <= 8'h00;
			amp_c_electrode <= 8'h00;
		end else begin
			amp_b_electrode <= amp_b_power_on ? (8'h01 << amp_b_input_select) : 8'h00;
			amp_c_electrode <= amp_c_power_on ? (8'h01 << amp_c_input_select) : 8'h00;
		end
	end

	// Terminal mode from powered amplifiers
	always_comb begin
		case ({amp_b_power_on, amp_c_power_on})
			2'h3:    term_mode_next = CTAS_TERM_AVERAGE;
			2'h2:    term_mode_next = CTAS_TERM_BUFFER;
			2'h1:    term_mode_next = CTAS_TERM_BUFFER;
			default: term_mode_next = CTAS_TERM_OFF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			term_mode <= CTAS_TERM_OFF;
		end else begin
			term_mode <= term_mode_next;
		end
	end

	// Per-channel input select registers and leg drive routing
	genvar gi;
	generate
		for (gi = 0; gi < CH_COUNT; gi++) begin : g_ch
			always_ff @(posedge clk) begin
				if (rst) begin
					channel_input_select_reg[gi] <= `CTAS_CH_SELECT_RESET;
				end else if (reg_write && reg_addr == (`CTAS_CH_SELECT_BASE + 8'(gi))) begin
					channel_input_select_reg[gi] <= reg_wdata[2:0];
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					leg_drive_to_p[gi]         <= 1'h0;
					leg_drive_to_n[gi]         <= 1'h0;
					leg_drive_vs_reference[gi] <= 1'h0;
				end else begin
					leg_drive_to_p[gi] <= channel_input_select_reg[gi] == `CTAS_SEL_LEG_DRIVE_P;
					leg_drive_to_n[gi] <= channel_input_select_reg[gi] == `CTAS_SEL_LEG_DRIVE_N;
					// The other input of a routed channel sits on the drive reference
					leg_drive_vs_reference[gi] <= channel_input_select_reg[gi] == `CTAS_SEL_LEG_DRIVE_P ||
						channel_input_select_reg[gi] == `CTAS_SEL_LEG_DRIVE_N;
				end
			end

			// Per-channel select and routing checks
			sel_reset_a: assert property (@(posedge clk)
				rst
				|=> channel_input_select_reg[gi] == `CTAS_CH_SELECT_RESET)
				else $error("channel select not cleared by reset");
			sel_write_a: assert property (@(posedge clk) disable iff (rst)
				reg_write && reg_addr == (`CTAS_CH_SELECT_BASE + 8'(gi))
				|=> channel_input_select_reg[gi] == $past(reg_wdata[2:0]))
				else $error("channel select did not take write");
			sel_hold_a: assert property (@(posedge clk) disable iff (rst)
				!(reg_write && reg_addr == (`CTAS_CH_SELECT_BASE + 8'(gi)))
				|=> $stable(channel_input_select_reg[gi]))
				else $error("channel select changed without a write");
			leg_p_a: assert property (@(posedge clk) disable iff (rst)
				channel_input_select_reg[gi] == `CTAS_SEL_LEG_DRIVE_P
				|=> leg_drive_to_p[gi] && !leg_drive_to_n[gi] && leg_drive_vs_reference[gi])
				else $error("leg drive not routed to P side");
			leg_n_a: assert property (@(posedge clk) disable iff (rst)
				channel_input_select_reg[gi] == `CTAS_SEL_LEG_DRIVE_N
				|=> leg_drive_to_n[gi] && !leg_drive_to_p[gi] && leg_drive_vs_reference[gi])
				else $error("leg drive not routed to N side");
			leg_excl_a: assert property (@(posedge clk) disable iff (rst)
				leg_drive_to_p[gi]
				|-> !leg_drive_to_n[gi] && leg_drive_vs_reference[gi])
				else $error("leg drive on both sides");
			leg_none_a: assert property (@(posedge clk) disable iff (rst)
				channel_input_select_reg[gi] < `CTAS_SEL_LEG_DRIVE_P
				|=> !leg_drive_to_p[gi] && !leg_drive_to_n[gi] && !leg_drive_vs_reference[gi])
				else $error("leg drive routed for a normal input");
			ch_read_a: assert property (@(posedge clk) disable iff (rst)
				reg_read && reg_addr == (`CTAS_CH_SELECT_BASE + 8'(gi))
				|=> reg_rdata == {5'h00, $past(channel_input_select_reg[gi])})
				else $error("channel select read back wrong");
		end
	endgenerate

	// Read mux, no side effects
	always_comb begin
		reg_rdata_next = 8'h00;
		if (reg_addr == `CTAS_BC_CONTROL_ADDR) begin
			reg_rdata_next = center_terminal_bc_control_reg;
		end
		for (int i = 0; i < CH_COUNT; i++) begin
			if (reg_addr == (`CTAS_CH_SELECT_BASE + 8'(i))) begin
				reg_rdata_next = {5'h00, channel_input_select_reg[i]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= reg_rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Assertions
	ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR |=> center_terminal_bc_control_reg == $past(reg_wdata))
		else $error("control register did not take write");
	amp_c_power_a: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR |=> amp_c_power_on == $past(reg_wdata[7]))
		else $error("amp C power bit wrong");
	amp_b_power_a: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR |=> amp_b_power_on == $past(reg_wdata[6]))
		else $error("amp B power bit wrong");
	amp_b_sel_a: assert property (@(posedge clk) disable iff (rst)
		amp_b_power_on && $stable(amp_b_power_on) |=> amp_b_electrode == (8'h01 << $past(amp_b_input_select)))
		else $error("amp B electrode select wrong");
	amp_c_sel_a: assert property (@(posedge clk) disable iff (rst)
		amp_c_power_on |=> amp_c_electrode == (8'h01 << $past(amp_c_input_select)))
		else $error("amp C electrode select wrong");
	leg_route_a: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `CTAS_CH_SELECT_BASE && reg_wdata[2:0] == `CTAS_SEL_LEG_DRIVE_N
		##1 !(reg_write && reg_addr == `CTAS_CH_SELECT_BASE) |=> leg_drive_to_n[0] && !leg_drive_to_p[0])
		else $error("leg drive not routed to N side");
	leg_ref_a: assert property (@(posedge clk) disable iff (rst)
		leg_drive_vs_reference[0] ==
		($past(channel_input_select_reg[0]) inside {`CTAS_SEL_LEG_DRIVE_P, `CTAS_SEL_LEG_DRIVE_N}))
		else $error("reference flag mismatch");
	term_avg_a: assert property (@(posedge clk) disable iff (rst)
		amp_b_power_on && amp_c_power_on |=> term_mode == CTAS_TERM_AVERAGE)
		else $error("terminal not averaging");
	read_back_a: assert property (@(posedge clk) disable iff (rst)
		reg_read && reg_addr == `CTAS_BC_CONTROL_ADDR |=> reg_rdata == $past(center_terminal_bc_control_reg))
		else $error("read back wrong");

	// Reset values
	ctrl_reset_a: assert property (@(posedge clk)
		rst
		|=> center_terminal_bc_control_reg == `CTAS_BC_CONTROL_RESET)
		else $error("control register not cleared by reset");
	amp_c_reset_a: assert property (@(posedge clk)
		rst
		|=> !amp_c_power_on)
		else $error("amp C powered after reset");
	amp_b_reset_a: assert property (@(posedge clk)
		rst
		|=> !amp_b_power_on)
		else $error("amp B powered after reset");
	elec_reset_a: assert property (@(posedge clk)
		rst
		|=> amp_b_electrode == 8'h00 && amp_c_electrode == 8'h00)
		else $error("electrode select not cleared by reset");
	mode_reset_a: assert property (@(posedge clk)
		rst
		|=> term_mode == CTAS_TERM_OFF)
		else $error("terminal mode not off after reset");
	rdata_reset_a: assert property (@(posedge clk)
		rst
		|=> reg_rdata == 8'h00)
		else $error("read data not cleared by reset");

	// Control register fields
	ctrl_hold_a: assert property (@(posedge clk) disable iff (rst)
		!(reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR)
		|=> $stable(center_terminal_bc_control_reg))
		else $error("control register changed without a write");
	b_field_a: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR
		|=> amp_b_input_select == $past(reg_wdata[`CTAS_AMP_B_SEL_HI:`CTAS_AMP_B_SEL_LO]))
		else $error("amp B select field wrong");
	c_field_a: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `CTAS_BC_CONTROL_ADDR
		|=> amp_c_input_select == $past(reg_wdata[`CTAS_AMP_C_SEL_HI:`CTAS_AMP_C_SEL_LO]))
		else $error("amp C select field wrong");

	// Electrode selects
	amp_b_off_a: assert property (@(posedge clk) disable iff (rst)
		!amp_b_power_on
		|=> amp_b_electrode == 8'h00)
		else $error("amp B electrode driven while off");
	amp_c_off_a: assert property (@(posedge clk) disable iff (rst)
		!amp_c_power_on
		|=> amp_c_electrode == 8'h00)
		else $error("amp C electrode driven while off");
	amp_b_onehot_a: assert property (@(posedge clk) disable iff (rst)
		amp_b_power_on
		|=> $onehot(amp_b_electrode))
		else $error("amp B electrode not one-hot");
	amp_c_onehot_a: assert property (@(posedge clk) disable iff (rst)
		amp_c_power_on
		|=> $onehot(amp_c_electrode))
		else $error("amp C electrode not one-hot");

	// Each select code against its electrode
	for (genvar gk = 0; gk < 8; gk++) begin : g_code
		b_code_a: assert property (@(posedge clk) disable iff (rst)
			amp_b_power_on && amp_b_input_select == 3'(gk)
			|=> amp_b_electrode == (8'h01 << gk))
			else $error("amp B code maps to wrong electrode");
		c_code_a: assert property (@(posedge clk) disable iff (rst)
			amp_c_power_on && amp_c_input_select == 3'(gk)
			|=> amp_c_electrode == (8'h01 << gk))
			else $error("amp C code maps to wrong electrode");
	end

	// Terminal mode
	term_buf_a: assert property (@(posedge clk) disable iff (rst)
		amp_b_power_on != amp_c_power_on
		|=> term_mode == CTAS_TERM_BUFFER)
		else $error("terminal not buffering");
	term_off_a: assert property (@(posedge clk) disable iff (rst)
		!amp_b_power_on && !amp_c_power_on
		|=> term_mode == CTAS_TERM_OFF)
		else $error("terminal not off");
	avg_pair_a: assert property (@(posedge clk) disable iff (rst)
		term_mode == CTAS_TERM_AVERAGE
		|-> $onehot(amp_b_electrode) && $onehot(amp_c_electrode))
		else $error("averaging without two electrodes");
	buf_single_a: assert property (@(posedge clk) disable iff (rst)
		term_mode == CTAS_TERM_BUFFER
		|-> $onehot(amp_b_electrode | amp_c_electrode))
		else $error("buffering without one electrode");
	off_none_a: assert property (@(posedge clk) disable iff (rst)
		term_mode == CTAS_TERM_OFF
		|-> amp_b_electrode == 8'h00 && amp_c_electrode == 8'h00)
		else $error("electrode selected while terminal off");

	// Read port
	read_idle_a: assert property (@(posedge clk) disable iff (rst)
		!reg_read
		|=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	read_unmapped_a: assert property (@(posedge clk) disable iff (rst)
		reg_read && reg_addr != `CTAS_BC_CONTROL_ADDR && (reg_addr < `CTAS_CH_SELECT_BASE ||
		reg_addr >= `CTAS_CH_SELECT_BASE + 8'(CH_COUNT)) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ==== src/ctas_pkg.sv ====
// Types for the center terminal amplifier select block
package ctas_pkg;
	typedef enum logic [1:0] {
		CTAS_TERM_OFF,
		CTAS_TERM_BUFFER,
		CTAS_TERM_AVERAGE
	} ctas_term_mode_t;
endpackage

// ==== src/ctas_regs.svh ====
// Register offsets, field positions and reset values for the center terminal control block
`ifndef CTAS_REGS_SVH
`define CTAS_REGS_SVH
`define CTAS_BC_CONTROL_ADDR   8'h19
`define CTAS_BC_CONTROL_RESET  8'h00
`define CTAS_CH_SELECT_BASE    8'h05
`define CTAS_CH_COUNT          8
`define CTAS_AMP_C_POWER_BIT   7
`define CTAS_AMP_B_POWER_BIT   6
`define CTAS_AMP_B_SEL_HI      5
`define CTAS_AMP_B_SEL_LO      3
`define CTAS_AMP_C_SEL_HI      2
`define CTAS_AMP_C_SEL_LO      0
`define CTAS_CH_SELECT_RESET   3'h0
`define CTAS_SEL_LEG_DRIVE_P   3'h6
`define CTAS_SEL_LEG_DRIVE_N   3'h7
`endif

// ==== testbench/ctas_center_terminal_test.sv ====
// Self-checking bench for the center terminal amplifier select block
`timescale 1ns/1ps
`default_nettype none
`include "ctas_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module ctas_center_terminal_test;
	import ctas_pkg::*;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic [7:0]      reg_addr = 8'h00;
	logic [7:0]      reg_wdata = 8'h00;
	logic            reg_write = 1'b0;
	logic            reg_read = 1'b0;
	logic [7:0]      reg_rdata;
	logic            amp_b_power_on;
	logic            amp_c_power_on;
	logic [7:0]      amp_b_electrode;
	logic [7:0]      amp_c_electrode;
	ctas_term_mode_t term_mode;
	logic [7:0]      leg_drive_to_p;
	logic [7:0]      leg_drive_to_n;
	logic [7:0]      leg_drive_vs_reference;
	int              err_total = 0;
	int              total_checks = 0;
	ctas_center_terminal u_ctas_center_terminal (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.amp_b_power_on(amp_b_power_on), .amp_c_power_on(amp_c_power_on),
		.amp_b_electrode(amp_b_electrode), .amp_c_electrode(amp_c_electrode), .term_mode(term_mode),
		.leg_drive_to_p(leg_drive_to_p), .leg_drive_to_n(leg_drive_to_n),
		.leg_drive_vs_reference(leg_drive_vs_reference));
	always #12.5 clk = ~clk;
	task automatic stop_test();
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Write, then let the derived outputs settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		`CHK(reg_rdata, exp)
	endtask
	task automatic t_reset();
		rd(`CTAS_BC_CONTROL_ADDR, 8'h00);
		`CHK(amp_c_power_on, 1'b0)
		`CHK(amp_b_power_on, 1'b0)
		`CHK(term_mode, CTAS_TERM_OFF)
	endtask
	task automatic t_codes();
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = {2'b11, i[2:0], 3'(7 - i)};
			wr(`CTAS_BC_CONTROL_ADDR, v);
			`CHK(amp_b_electrode, 8'h01 << i)
			`CHK(amp_c_electrode, 8'h01 << (7 - i))
			`CHK(term_mode, CTAS_TERM_AVERAGE)
			rd(`CTAS_BC_CONTROL_ADDR, v);
		end
	endtask
	task automatic t_single();
		wr(`CTAS_BC_CONTROL_ADDR, 8'h5A);
		`CHK({amp_c_power_on, amp_b_power_on}, 2'b01)
		`CHK({amp_b_electrode, amp_c_electrode}, 16'h0800)
		`CHK(term_mode, CTAS_TERM_BUFFER)
		wr(`CTAS_BC_CONTROL_ADDR, 8'h85);
		`CHK({amp_c_power_on, amp_b_power_on}, 2'b10)
		`CHK({amp_b_electrode, amp_c_electrode}, 16'h0020)
		`CHK(term_mode, CTAS_TERM_BUFFER)
		wr(`CTAS_BC_CONTROL_ADDR, 8'h00);
		`CHK(term_mode, CTAS_TERM_OFF)
	endtask
	task automatic t_leg();
		for (int n = 0; n < 8; n++) begin
			wr(8'h05 + 8'(n), n[0] ? 8'h06 : 8'h07); // every channel routed, so all measured against the drive reference
		end
		`CHK(leg_drive_to_p, 8'hAA)
		`CHK(leg_drive_to_n, 8'h55)
		`CHK(leg_drive_vs_reference, 8'hFF)
		rd(8'h06, 8'h06);
		wr(8'h05, 8'hFD);
		rd(8'h05, 8'h05);
		`CHK(leg_drive_to_n, 8'h54)
		`CHK(leg_drive_to_p, 8'hAA)
		`CHK(leg_drive_vs_reference, 8'hFE)
		wr(8'h1A, 8'hFF);
		rd(8'h1A, 8'h00);
		rd(`CTAS_BC_CONTROL_ADDR, 8'h00);
	endtask
	// Reset in mid-run after every output except reg_rdata has been set
	task automatic t_rerst();
		wr(`CTAS_BC_CONTROL_ADDR, 8'hFF);
		wr(8'h0C, 8'h07);
		`CHK(leg_drive_to_n, 8'hD4)
		`CHK(amp_c_electrode, 8'h80)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK({amp_c_power_on, amp_b_power_on}, 2'h0)
		`CHK({amp_b_electrode, amp_c_electrode}, 16'h0000)
		`CHK(term_mode, CTAS_TERM_OFF)
		`CHK(leg_drive_to_n, 8'h00)
		`CHK(leg_drive_vs_reference, 8'h00)
		rd(8'h0C, 8'h00);
		rd(`CTAS_BC_CONTROL_ADDR, 8'h00);
	endtask
	initial begin
		#(2000 * 25);
		err_total++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_codes();
		t_single();
		t_leg();
		t_rerst();
		stop_test();
	end
endmodule
`default_nettype wire
